// ==== core/pmirq_arbiter.sv ====
// module: combinational priority pick among eligible sources
// assumes in-service flags come from the dispatcher
`timescale 1ns/1ps
module pmirq_arbiter (
    input wire logic [pmirq_pkg::N_SRC-1:0] i_req,
    input wire logic [pmirq_pkg::N_SRC-1:0] i_prio, // one level bit per source
    input wire logic i_act_hi,
    input wire logic i_act_lo,
    output logic o_valid,
    output logic o_hi,
    output logic [3:0] o_idx
);
    import pmirq_pkg::*;
    // lowest index wins a tie
    function automatic logic [3:0] first_set(input logic [N_SRC-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : first_set
    logic [N_SRC-1:0] hi_req;
    always_comb begin
        hi_req = i_req & i_prio;
        o_valid = 1'b0;
        o_hi = 1'b0;
        o_idx = 4'h0;
        if (i_act_hi) begin
            o_valid = 1'b0; // high routine never preempted
        end else if (|hi_req) begin
            o_valid = 1'b1; // high level first
            o_hi = 1'b1;
            o_idx = first_set(hi_req);
        end else if (!i_act_lo && |i_req) begin
            o_valid = 1'b1;
            o_idx = first_set(i_req);
        end
    end
endmodule : pmirq_arbiter

// ==== core/pmirq_pkg.sv ====
// package: power mode and irq dispatch constants, types, register map
// assumes a 20 MHz system clock and an axi4-lite register bus
// What this block does
// - idle bit halts cpu after writing instruction
// - idle keeps registers, clocks, peripherals running
// - enabled interrupt clears idle, resumes and services
// - reset ends idle, restart at address zero
// - watchdog counts in idle, resets unless disabled
// - stop bit halts cpu and oscillators after instruction
// - only reset ends stop, restart at zero
// - clock detector runs in stop, may reset
// - sixteen sources, two priority levels each
// - pending sets in every mode except stop; disabled source never requests
// - enabled pending source long-calls its vector
// - return resumes the interrupted instruction stream
// - global enable gates every source enable
// - blocked requests stay pending until enabled
// - enable clear races a single-cycle follower
// - some flags cleared by hardware on vector
// - flag still set after return requests again
// - high preempts low, ties by fixed order
// - sampled every cycle, five cycle response
// - software-set pending flag acts like hardware
package pmirq_pkg;
    localparam int N_SRC = 16; // number of interrupt sources
    // register byte offsets
    localparam logic [7:0] OFF_PWR = 8'h00; // power_mode_control
    localparam logic [7:0] OFF_IEN = 8'h04; // per-source enables
    localparam logic [7:0] OFF_GEN = 8'h08; // global_irq_enable word
    localparam logic [7:0] OFF_PRI = 8'h0c; // priority, 1 = high
    localparam logic [7:0] OFF_PND = 8'h10; // pending flags
    localparam logic [7:0] OFF_WDC = 8'h14; // watchdog / clock detector control
    localparam logic [7:0] OFF_STA = 8'h18; // status, read only
    // field positions
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_STOP_BIT = 1;
    localparam int GEN_BIT = 7;
    localparam int WDC_EN_BIT = 0; // watchdog enable
    localparam int WDC_LOCK_BIT = 1; // once set, watchdog cannot be disabled
    localparam int WDC_CKMON_BIT = 2; // missing clock detector enable
    localparam int WDC_KICK_BIT = 3; // write 1 restarts the watchdog
    // reset values
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [15:0] IEN_RST = 16'h0000;
    localparam logic [15:0] PRI_RST = 16'h0000;
    localparam logic [3:0] WDC_RST = 4'h1; // watchdog on after reset
    // vector layout: base + index * step
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_STEP_SHIFT = 3;
    localparam logic [2:0] CALL_CYCLES = 3'd4; // cycles to finish the long call
    // clock detector timeout
    localparam int CLK_MHZ = 20;
    localparam int CKMON_TIMEOUT_US = 100;
    localparam int CKMON_CYCLES = CKMON_TIMEOUT_US * CLK_MHZ;
    typedef enum logic [2:0] {
        PM_RUN = 3'b000,
        PM_IDLE_ARM = 3'b001,
        PM_IDLE = 3'b010,
        PM_STOP_ARM = 3'b011,
        PM_STOP = 3'b100
    } pmirq_state_e;
endpackage : pmirq_pkg

// ==== core/pmirq_timer.sv ====
// module: timeout counter, one-cycle expire pulse when count reached
// assumes run and clear are synchronous to i_clk
`timescale 1ns/1ps
module pmirq_timer #(
    parameter int COUNT = 2000
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_run,
    input wire logic i_clear,
    output logic o_expire
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);
    logic [W-1:0] cnt_q; // cycles counted so far
    // count while running, restart on clear or expiry
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q <= '0;
            o_expire <= 1'b0;
        end else if (i_clear || !i_run) begin
            cnt_q <= '0;
            o_expire <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
            o_expire <= 1'b1;
        end else begin
            cnt_q <= cnt_q + W'(1);
            o_expire <= 1'b0;
        end
    end
endmodule : pmirq_timer

// ==== core/pmirq_top.sv ====
// module: power mode control and interrupt dispatch for a small cpu core
// assumes i_instr_done pulses at each instruction boundary and
// i_ret_done pulses together with it when the return completes
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pmirq_top #(
    parameter int WDOG_CYCLES = 65536, // watchdog timeout in system clocks
    parameter logic [pmirq_pkg::N_SRC-1:0] HW_CLR_MASK = 16'h000f // flags cleared on vector
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // axi4-lite slave
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // cpu sequencer and sources
    input wire logic [pmirq_pkg::N_SRC-1:0] I_SRC_EVENT,
    input wire logic I_INSTR_DONE,
    input wire logic I_RET_DONE,
    output logic O_CPU_HALT,
    output logic O_OSC_EN,
    output logic O_LONG_CALL,
    output logic [15:0] O_CALL_ADDR,
    output logic O_SYS_RESET
);
    import pmirq_pkg::*;
    pmirq_state_e state_q; // power mode state
    logic [7:0] pwr_q; // power_mode_control
    logic [N_SRC-1:0] ien_q; // per-source enables
    logic gen_q; // global_irq_enable
    logic [N_SRC-1:0] pri_q; // priority levels
    logic [N_SRC-1:0] pnd_q; // pending flags
    logic [N_SRC-1:0] pnd_d;
    logic wdog_en_q, wdog_lock_q, ckmon_en_q;
    logic act_hi_q, act_lo_q; // routines in service
    logic [2:0] call_cnt_q; // long call cycles left
    logic [3:0] last_idx_q; // last source vectored
    logic soft_rst; // internal reset, acts like a synchronous clear
    logic wr_fire, rd_fire; // bus accesses this cycle
    logic [31:0] rd_data;
    logic rd_ok, wr_ok;
    logic wdog_exp, ckmon_exp, wdog_kick;
    logic arb_valid, arb_hi;
    logic [3:0] arb_idx;
    logic dispatch; // start of a long call
    logic wake; // idle left by an interrupt

    assign soft_rst = O_SYS_RESET;
    assign wr_fire = O_AWREADY && O_WREADY;
    assign rd_fire = O_ARREADY;
    assign wr_ok = I_AWADDR <= OFF_STA && I_AWADDR[1:0] == 2'b00;
    assign wdog_kick = wr_fire && wr_ok && I_AWADDR == OFF_WDC
        && I_WSTRB[0] && I_WDATA[WDC_KICK_BIT];

    // vector address of a source
    function automatic logic [15:0] vec_of(input logic [3:0] idx);
        return VEC_BASE + ({12'h000, idx} << VEC_STEP_SHIFT);
    endfunction : vec_of

    // only enabled sources under global enable may request
    pmirq_arbiter u_arb (
        .i_req(pnd_q & ien_q & {N_SRC{gen_q}}),
        .i_prio(pri_q),
        .i_act_hi(act_hi_q),
        .i_act_lo(act_lo_q),
        .o_valid(arb_valid),
        .o_hi(arb_hi),
        .o_idx(arb_idx)
    );

    // watchdog keeps running in idle, stops with the oscillator
    pmirq_timer #(.COUNT(WDOG_CYCLES)) u_wdog (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_run(wdog_en_q && state_q != PM_STOP && !soft_rst),
        .i_clear(wdog_kick),
        .o_expire(wdog_exp)
    );

    // clock detector only watches while stopped
    pmirq_timer #(.COUNT(CKMON_CYCLES)) u_ckmon (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_run(ckmon_en_q && state_q == PM_STOP && !soft_rst),
        .i_clear(1'b0),
        .o_expire(ckmon_exp)
    );

    // dispatch at an instruction boundary, not on the return itself
    // while idle no instruction runs, so wake goes straight
    assign wake = state_q == PM_IDLE && arb_valid;
    assign dispatch = arb_valid && call_cnt_q == 3'd0 && !soft_rst
        && ((state_q == PM_RUN && I_INSTR_DONE && !I_RET_DONE) || wake);

    // internal reset pulse from either timer
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_SYS_RESET <= 1'b0;
        end else begin
            O_SYS_RESET <= wdog_exp || ckmon_exp;
        end
    end

    // power mode sequencing
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_q <= PM_RUN;
        end else if (soft_rst) begin
            state_q <= PM_RUN; // fetch restarts at the reset vector
        end else begin
            unique case (state_q)
                PM_RUN: begin
                    // stop wins when both bits are written
                    if (pwr_q[PWR_STOP_BIT]) begin
                        state_q <= PM_STOP_ARM;
                    end else if (pwr_q[PWR_IDLE_BIT]) begin
                        state_q <= PM_IDLE_ARM;
                    end
                end
                PM_IDLE_ARM: begin
                    if (pwr_q[PWR_STOP_BIT]) begin
                        state_q <= PM_STOP_ARM;
                    end else if (I_INSTR_DONE) begin
                        state_q <= PM_IDLE; // writing instruction finished
                    end
                end
                PM_IDLE: begin
                    if (wake) begin
                        state_q <= PM_RUN;
                    end
                end
                PM_STOP_ARM: begin
                    if (I_INSTR_DONE) begin
                        state_q <= PM_STOP;
                    end
                end
                PM_STOP: begin
                    state_q <= PM_STOP; // only a reset leaves
                end
                default: begin
                    state_q <= PM_RUN;
                end
            endcase
        end
    end

    // halt and oscillator outputs, registered from next state
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_CPU_HALT <= 1'b0;
            O_OSC_EN <= 1'b1;
        end else begin
            // clocks run in idle, only the cpu is held
            O_CPU_HALT <= !soft_rst && !wake && (state_q == PM_STOP || state_q == PM_IDLE
                || (I_INSTR_DONE && (state_q == PM_STOP_ARM
                || (state_q == PM_IDLE_ARM && !pwr_q[PWR_STOP_BIT]))));
            O_OSC_EN <= soft_rst || !(state_q == PM_STOP
                || (state_q == PM_STOP_ARM && I_INSTR_DONE));
        end
    end

    // long call: vector held four cycles, in-service levels tracked
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            call_cnt_q <= 3'd0;
            O_LONG_CALL <= 1'b0;
            O_CALL_ADDR <= VEC_RESET;
            act_hi_q <= 1'b0;
            act_lo_q <= 1'b0;
            last_idx_q <= 4'h0;
        end else if (soft_rst) begin
            call_cnt_q <= 3'd0;
            O_LONG_CALL <= 1'b0;
            O_CALL_ADDR <= VEC_RESET;
            act_hi_q <= 1'b0;
            act_lo_q <= 1'b0;
            last_idx_q <= 4'h0;
        end else if (dispatch) begin
            call_cnt_q <= CALL_CYCLES;
            O_LONG_CALL <= 1'b1;
            O_CALL_ADDR <= vec_of(arb_idx);
            last_idx_q <= arb_idx;
            if (arb_hi) begin
                act_hi_q <= 1'b1;
            end else begin
                act_lo_q <= 1'b1;
            end
        end else begin
            if (call_cnt_q > 3'd1) begin
                call_cnt_q <= call_cnt_q - 3'd1;
            end else begin
                call_cnt_q <= 3'd0;
                O_LONG_CALL <= 1'b0;
            end
            // return closes the innermost routine
            if (I_RET_DONE) begin
                if (act_hi_q) begin
                    act_hi_q <= 1'b0;
                end else begin
                    act_lo_q <= 1'b0;
                end
            end
        end
    end

    // pending flags: software write, hardware clear on vector, event set wins
    always_comb begin
        pnd_d = pnd_q;
        if (wr_fire && wr_ok && I_AWADDR == OFF_PND) begin
            if (I_WSTRB[0]) pnd_d[7:0] = I_WDATA[7:0]; // ones act as events
            if (I_WSTRB[1]) pnd_d[15:8] = I_WDATA[15:8];
        end
        if (dispatch) begin
            pnd_d = pnd_d & ~(HW_CLR_MASK & (16'h0001 << arb_idx));
        end
        if (state_q != PM_STOP) begin
            pnd_d = pnd_d | I_SRC_EVENT; // set regardless of enable
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pnd_q <= '0;
        end else if (soft_rst) begin
            pnd_q <= '0;
        end else begin
            pnd_q <= pnd_d;
        end
    end

    // software registers
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pwr_q <= PWR_RST;
            ien_q <= IEN_RST;
            gen_q <= 1'b0;
            pri_q <= PRI_RST;
            wdog_en_q <= WDC_RST[WDC_EN_BIT];
            wdog_lock_q <= WDC_RST[WDC_LOCK_BIT];
            ckmon_en_q <= WDC_RST[WDC_CKMON_BIT];
        end else if (soft_rst) begin
            pwr_q <= PWR_RST;
            ien_q <= IEN_RST;
            gen_q <= 1'b0;
            pri_q <= PRI_RST;
            wdog_en_q <= WDC_RST[WDC_EN_BIT];
            wdog_lock_q <= WDC_RST[WDC_LOCK_BIT];
            ckmon_en_q <= WDC_RST[WDC_CKMON_BIT];
        end else begin
            if (wake) begin
                pwr_q[PWR_IDLE_BIT] <= 1'b0;
            end else if (wr_fire && wr_ok && I_AWADDR == OFF_PWR && I_WSTRB[0]) begin
                pwr_q <= {6'b000000, I_WDATA[1:0]}; // reserved bits stay zero
            end
            if (wr_fire && wr_ok && I_AWADDR == OFF_IEN) begin
                if (I_WSTRB[0]) ien_q[7:0] <= I_WDATA[7:0];
                if (I_WSTRB[1]) ien_q[15:8] <= I_WDATA[15:8];
            end
            if (wr_fire && wr_ok && I_AWADDR == OFF_GEN && I_WSTRB[0]) begin
                // a clear lands after this edge, so a call picked on it still goes
                gen_q <= I_WDATA[GEN_BIT];
            end
            if (wr_fire && wr_ok && I_AWADDR == OFF_PRI) begin
                if (I_WSTRB[0]) pri_q[7:0] <= I_WDATA[7:0];
                if (I_WSTRB[1]) pri_q[15:8] <= I_WDATA[15:8];
            end
            if (wr_fire && wr_ok && I_AWADDR == OFF_WDC && I_WSTRB[0]) begin
                // a locked watchdog ignores the disable
                wdog_en_q <= I_WDATA[WDC_EN_BIT] || wdog_lock_q;
                wdog_lock_q <= wdog_lock_q || I_WDATA[WDC_LOCK_BIT];
                ckmon_en_q <= I_WDATA[WDC_CKMON_BIT];
            end
        end
    end

    // read mux; unmapped or misaligned reads answer slverr with zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (I_ARADDR)
            OFF_PWR: rd_data = {24'h000000, pwr_q};
            OFF_IEN: rd_data = {16'h0000, ien_q};
            OFF_GEN: rd_data = {24'h000000, gen_q, 7'h00};
            OFF_PRI: rd_data = {16'h0000, pri_q};
            OFF_PND: rd_data = {16'h0000, pnd_q};
            OFF_WDC: rd_data = {28'h0000000, 1'b0, ckmon_en_q, wdog_lock_q, wdog_en_q};
            OFF_STA: rd_data = {20'h00000, last_idx_q, O_LONG_CALL, act_hi_q,
                act_lo_q, O_OSC_EN, O_CPU_HALT, state_q};
            default: rd_ok = 1'b0;
        endcase
    end

    // write channel: address and data taken together, one per response
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            O_BVALID <= 1'b0;
            O_BRESP <= 2'b00;
        end else begin
            O_AWREADY <= I_AWVALID && I_WVALID && !O_AWREADY && !O_BVALID;
            O_WREADY <= I_AWVALID && I_WVALID && !O_AWREADY && !O_BVALID;
            if (wr_fire) begin
                O_BVALID <= 1'b1;
                O_BRESP <= wr_ok ? 2'b00 : 2'b10;
            end else if (I_BREADY) begin
                O_BVALID <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= 2'b00;
        end else begin
            O_ARREADY <= I_ARVALID && !O_ARREADY && !O_RVALID;
            if (rd_fire) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rd_data;
                O_RRESP <= rd_ok ? 2'b00 : 2'b10;
            end else if (I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    property p_idle_enter;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (state_q == PM_IDLE_ARM && I_INSTR_DONE && !pwr_q[PWR_STOP_BIT] && !soft_rst)
            |=> (state_q == PM_IDLE && O_CPU_HALT);
    endproperty
    a_idle_enter: assert property (p_idle_enter) else $error("idle not entered");
    property p_idle_clk;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (state_q == PM_IDLE) |-> O_OSC_EN;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock off in idle");
    property p_wake;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (wake && !soft_rst) |=> (state_q == PM_RUN && !pwr_q[PWR_IDLE_BIT] && O_LONG_CALL);
    endproperty
    a_wake: assert property (p_wake) else $error("idle wake failed");
    property p_stop_hold;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (state_q == PM_STOP && !soft_rst) |=> (state_q == PM_STOP && !O_OSC_EN);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left");
    property p_rst_vec;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        soft_rst |=> (state_q == PM_RUN && O_CALL_ADDR == VEC_RESET && !O_CPU_HALT);
    endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("bad reset restart");
    property p_call_len;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (dispatch && !O_LONG_CALL) |=> O_LONG_CALL [*4] ##1 !O_LONG_CALL;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call length wrong");
    property p_gate;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        dispatch |-> (gen_q && ien_q[arb_idx] && pnd_q[arb_idx]);
    endproperty
    a_gate: assert property (p_gate) else $error("blocked source vectored");
    property p_hi_np;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        act_hi_q |-> !dispatch;
    endproperty
    a_hi_np: assert property (p_hi_np) else $error("high routine preempted");
    property p_evt;
        @(posedge I_CLK) disable iff (!I_RESET_N)
        (|I_SRC_EVENT && state_q != PM_STOP && !soft_rst)
            |=> ((pnd_q & $past(I_SRC_EVENT)) == $past(I_SRC_EVENT));
    endproperty
    a_evt: assert property (p_evt) else $error("event lost");
endmodule : pmirq_top

// ==== dv/pmirq_cpu_model.sv ====
// cpu sequencer model: instruction boundary every second cycle
// assumes halt and long call from the dispatcher freeze the sequencer
`timescale 1ns/1ps
module pmirq_cpu_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_halt,
    input wire logic i_long_call,
    input wire logic i_ret,
    output logic o_instr_done,
    output logic o_ret_done
);
    logic phase_q; // every instruction two cycles, so never single-cycle
    // boundaries only while running, never during the long call
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_q <= 1'b0;
            o_instr_done <= 1'b0;
            o_ret_done <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
            o_instr_done <= phase_q & ~i_halt & ~i_long_call;
            o_ret_done <= phase_q & ~i_halt & ~i_long_call & i_ret;
        end
    end
endmodule : pmirq_cpu_model

// ==== dv/tb_top.sv ====
// bench for the power mode and irq dispatch block
// assumes the cpu model drives the instruction boundary inputs
`timescale 1ns/1ps
module tb_top;
    import pmirq_pkg::*;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ret_rq = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, rdata;
    logic [1:0] bresp, rresp, rrs, wrs;
    logic [15:0] src = 0, call_addr;
    logic awr, wr_rdy, bv, arr, rv, idone, rdone, halt, osc, lc, sysrst;
    int n_errors = 0, samples_checked = 0;
    always #25 clk = ~clk;
    pmirq_top #(.WDOG_CYCLES(64)) DUT (.I_CLK(clk), .I_RESET_N(rst_n),
        .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hf),
        .I_WVALID(wv), .O_WREADY(wr_rdy), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br),
        .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rresp),
        .O_RVALID(rv), .I_RREADY(rr), .I_SRC_EVENT(src), .I_INSTR_DONE(idone),
        .I_RET_DONE(rdone), .O_CPU_HALT(halt), .O_OSC_EN(osc), .O_LONG_CALL(lc),
        .O_CALL_ADDR(call_addr), .O_SYS_RESET(sysrst));
    pmirq_cpu_model cpu (.i_clk(clk), .i_reset_n(rst_n), .i_halt(halt), .i_long_call(lc),
        .i_ret(ret_rq), .o_instr_done(idone), .o_ret_done(rdone));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // axi write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 0; wv <= 0;
        do @(posedge clk); while (bv !== 1'b1);
        wrs = bresp; br <= 0;
        @(posedge clk);
    endtask : wr
    task automatic rdx(input logic [7:0] a);
        ara <= a; arv <= 1; rr <= 1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge clk); while (rv !== 1'b1);
        rdata = rd; rrs = rresp; rr <= 0;
        @(posedge clk);
    endtask : rdx
    // bounded wait for a long call, then let it finish
    task automatic wait_call(input logic [15:0] a);
        for (int i = 0; i < 40 && lc !== 1'b1; i++) @(posedge clk);
        chk({31'h0, lc}, 1);
        chk({16'h0, call_addr}, {16'h0, a});
        repeat (6) @(posedge clk);
    endtask : wait_call
    task automatic wait_halt(input logic v);
        for (int i = 0; i < 300 && halt !== v; i++) @(posedge clk);
        chk({31'h0, halt}, {31'h0, v});
    endtask : wait_halt
    task automatic ret;
        ret_rq <= 1;
        do @(posedge clk); while (rdone !== 1'b1);
        ret_rq <= 0;
    endtask : ret
    task automatic pulse(input logic [15:0] s);
        src <= s;
        @(posedge clk);
        src <= 0;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic t_regs;
        rdx(OFF_PWR); chk(rdata, 0);
        rdx(8'h1c); chk({30'h0, rrs}, 2);
        wr(8'h1c, 32'h1); chk({30'h0, wrs}, 2);
        wr(OFF_WDC, 0); chk({30'h0, wrs}, 0);
        $display("test regs done");
    endtask : t_regs
    // blocked, then released; high level first, waiting low source called after return
    task automatic t_gate;
        wr(OFF_PRI, 32'h200); wr(OFF_IEN, 32'h223); wr(OFF_PND, 32'h220);
        repeat (20) @(posedge clk);
        chk({31'h0, lc}, 0);
        rdx(OFF_PND); chk(rdata, 32'h220);
        wr(OFF_GEN, 32'h80); wait_call(16'h004b);
        wr(OFF_PND, 32'h20); ret; wait_call(16'h002b);
        wr(OFF_PND, 0); ret;
        pulse(16'h0004); rdx(OFF_PND); chk(rdata, 4);
        wr(OFF_PND, 0); pulse(16'h0001); wait_call(16'h0003);
        rdx(OFF_PND); chk(rdata, 0);
        ret;
        $display("test dispatch done");
    endtask : t_gate
    task automatic t_idle;
        wr(OFF_PWR, 1); wait_halt(1);
        pulse(16'h0001); wait_call(16'h0003);
        chk({31'h0, halt}, 0);
        rdx(OFF_PWR); chk(rdata, 0);
        ret;
        $display("test idle done");
    endtask : t_idle
    task automatic t_stop; // analog loads modelled as already off
        wr(OFF_PWR, 3); wait_halt(1); chk({31'h0, osc}, 0);
        pulse(16'h0001); repeat (20) @(posedge clk);
        chk({30'h0, halt, lc}, 2);
        rst_n <= 0; repeat (5) @(posedge clk); rst_n <= 1; @(posedge clk);
        chk({15'h0, halt, call_addr}, 0);
        wr(OFF_PWR, 1); wait_halt(1);
        for (int i = 0; i < 100 && sysrst !== 1'b1; i++) @(posedge clk);
        chk({30'h0, sysrst, halt}, 3);
        wait_halt(0);
        $display("test stop done");
    endtask : t_stop
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        #(50 * 8000);
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_regs(); t_gate(); t_idle(); t_stop();
        print_verdict();
    end
endmodule : tb_top
